/* pkg/cfg_pkg.sv */
package cfg_pkg;
    // mode select codes for the test-port configuration mode
    localparam logic [2:0] MODE_TAP_A = 3'h5;
    localparam logic [2:0] MODE_TAP_B = 3'h1;
    // 32-bit synchronization word that realigns the byte stream
    localparam logic [31:0] SYNC_WORD = 32'haa995566;
    // host may ignore busy below this config clock rate
    localparam int NO_HANDSHAKE_FREQ_LIMIT_MHZ = 50;
    localparam int CLOCK_MHZ = 100;
    // memory clear time and its cycle count
    localparam int CLEAR_TIME_NS = 1000;
    localparam int CLEAR_CYCLES = (CLEAR_TIME_NS * CLOCK_MHZ + 999) / 1000;
    // cycles of internal work after an aborted packet
    localparam int ABORT_CYCLES = 4;
    // test-port instruction codes (5 bits)
    localparam logic [4:0] IR_CONFIG_IN = 5'h05;
    localparam logic [4:0] IR_STARTUP = 5'h0c;
    localparam int IR_WIDTH = 5;
    // start-up stage numbers: output tristate, set/reset plus write enable, end
    localparam logic [2:0] STAGE_GTS_DEFAULT = 3'h1;
    localparam logic [2:0] STAGE_GSR_DEFAULT = 3'h2;
    localparam logic [2:0] STAGE_LAST = 3'h3;
    typedef enum logic [2:0] {
        SEQ_CLEAR = 3'b000,
        SEQ_WAIT_INIT = 3'b001,
        SEQ_LOAD = 3'b010,
        SEQ_STARTUP = 3'b011,
        SEQ_RUN = 3'b100
    } seq_e;
endpackage

/* pkg/cfg_bus_if.sv */
// byte path from the test port into the sequencer, plus tap start-up step
interface cfg_bus_if;
    logic        byte_valid;
    logic [7:0]  byte_data;
    logic        startup_step;
    logic        tap_reset;
    modport src (output byte_valid, output byte_data, output startup_step, output tap_reset);
    modport dst (input byte_valid, input byte_data, input startup_step, input tap_reset);
endinterface

/* verilog/edge_sync.sv */
// two-flop synchroniser with rising edge detection on the second flop
module edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_s;
    sync_s state;
    sync_s next_state;

    // chain: meta only feeds sync
    always_comb begin
        next_state = state;
        next_state.meta = din;
        next_state.sync = state.meta;
        next_state.prev = state.sync;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.sync;
    assign rise = state.sync & ~state.prev;
endmodule

/* verilog/tap_loader.sv */
// minimal test access port: instruction register and config-in shifter
module tap_loader
    import cfg_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic tck_rise,
    input  wire logic tms,
    input  wire logic tdi,
    input  wire logic program_n,
    cfg_bus_if.src    bus
);
    typedef enum logic [3:0] {
        T_RESET = 4'h0, T_IDLE = 4'h1, T_SEL_DR = 4'h2, T_CAP_DR = 4'h3,
        T_SH_DR = 4'h4, T_EX1_DR = 4'h5, T_PA_DR = 4'h6, T_EX2_DR = 4'h7,
        T_UP_DR = 4'h8, T_SEL_IR = 4'h9, T_CAP_IR = 4'ha, T_SH_IR = 4'hb,
        T_EX1_IR = 4'hc, T_PA_IR = 4'hd, T_EX2_IR = 4'he, T_UP_IR = 4'hf
    } tap_e;
    typedef struct packed {
        tap_e                tap;
        logic [IR_WIDTH-1:0] ir_shift;
        logic [IR_WIDTH-1:0] ir;
        logic [7:0]          shift;
        logic [2:0]          count;
        logic                valid;
        logic                step;
    } tap_s;
    tap_s state;
    tap_s next_state;

    // standard state walk on each rising test clock edge
    function automatic tap_e tap_next(input tap_e s, input logic m);
        unique case (s)
            T_RESET:  tap_next = m ? T_RESET : T_IDLE;
            T_IDLE:   tap_next = m ? T_SEL_DR : T_IDLE;
            T_SEL_DR: tap_next = m ? T_SEL_IR : T_CAP_DR;
            T_CAP_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
            T_SH_DR:  tap_next = m ? T_EX1_DR : T_SH_DR;
            T_EX1_DR: tap_next = m ? T_UP_DR : T_PA_DR;
            T_PA_DR:  tap_next = m ? T_EX2_DR : T_PA_DR;
            T_EX2_DR: tap_next = m ? T_UP_DR : T_SH_DR;
            T_UP_DR:  tap_next = m ? T_SEL_DR : T_IDLE;
            T_SEL_IR: tap_next = m ? T_RESET : T_CAP_IR;
            T_CAP_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
            T_SH_IR:  tap_next = m ? T_EX1_IR : T_SH_IR;
            T_EX1_IR: tap_next = m ? T_UP_IR : T_PA_IR;
            T_PA_IR:  tap_next = m ? T_EX2_IR : T_PA_IR;
            T_EX2_IR: tap_next = m ? T_UP_IR : T_SH_IR;
            T_UP_IR:  tap_next = m ? T_SEL_DR : T_IDLE;
        endcase
    endfunction

    // shift paths; bytes leave msb first
    always_comb begin
        next_state = state;
        next_state.valid = 1'b0;
        next_state.step = 1'b0;
        if (!program_n) begin
            next_state = '0;
        end else if (tck_rise) begin
            next_state.tap = tap_next(state.tap, tms);
            if (state.tap == T_SH_IR) begin
                next_state.ir_shift = {tdi, state.ir_shift[IR_WIDTH-1:1]};
            end
            if (state.tap == T_UP_IR) begin
                next_state.ir = state.ir_shift;
            end
            if (state.tap == T_SH_DR && state.ir == IR_CONFIG_IN) begin
                next_state.shift = {state.shift[6:0], tdi};
                next_state.count = state.count + 3'h1;
                next_state.valid = (state.count == 3'h7);
            end
            if (state.tap == T_SH_DR && state.ir == IR_STARTUP) begin
                next_state.step = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign bus.byte_valid = state.valid;
    assign bus.byte_data = state.shift;
    assign bus.startup_step = state.step;
    assign bus.tap_reset = (state.tap == T_RESET);
endmodule

/* verilog/config_port_sequencer.sv */
// Notes on behaviour
// - byte accepted on edge when busy low
// - packet survives across chip-select gaps
// - no pacing busy below no-handshake rate
// - write/read switch aborts, busy until done
// - after abort wait for sync word
// - write release under select aborts next edge
// - reconfig low holds test port reset
// - config-in shifts test data into packets
// - mode 101 or 001 selects test port
// - clear, load, then start-up in order
// - start at power-up and on reconfig
// - init released after clear, done at end of load
// - external init low stalls before load
// - tristate then set/reset, write release
// - start-up stages configurable, done and lock waits
// - readback of the last loaded word
// - busy active high, host holds byte
// - read direction drives readback data
// - msb on data line 0
module config_port_sequencer
    import cfg_pkg::*;
#(
    parameter int LOAD_WORDS = 16,
    parameter int ABORT_LEN  = ABORT_CYCLES,
    parameter int BUSY_EVERY = 8
) (
    input  wire logic       CLOCK,
    input  wire logic       NRST,
    input  wire logic       CONFIG_CLOCK,
    input  wire logic       CS_N,
    input  wire logic       WRITE_N,
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE_N,
    output logic            BUSY,
    input  wire logic       PROGRAM_N,
    input  wire logic       INIT_IN,
    output logic            INIT_OUT,
    output logic            INIT_OE_N,
    output logic            DONE,
    input  wire logic       DONE_LINE,
    input  wire logic       MODE_SELECT_2,
    input  wire logic       MODE_SELECT_1,
    input  wire logic       MODE_SELECT_0,
    input  wire logic       TCK,
    input  wire logic       TMS,
    input  wire logic       TDI,
    input  wire logic       FAST_CLOCK,
    input  wire logic [2:0] GTS_STAGE,
    input  wire logic [2:0] GSR_STAGE,
    input  wire logic       WAIT_DONE_LINE,
    input  wire logic       WAIT_LOCK,
    input  wire logic [2:0] LOCK_STAGE,
    input  wire logic       CLOCK_LOCKED,
    output logic            GLOBAL_OUTPUT_TRISTATE,
    output logic            GLOBAL_SET_RESET,
    output logic            GLOBAL_WRITE_ENABLE,
    output logic            TAP_MODE,
    output logic            SYNCED
);
    initial begin
        if (LOAD_WORDS < 1 || LOAD_WORDS > 65535 || ABORT_LEN < 1 || ABORT_LEN > 255
            || BUSY_EVERY < 2 || BUSY_EVERY > 255) begin
            $error("config_port_sequencer: unsupported parameter");
        end
    end

    localparam logic [15:0] LOAD_LAST = 16'(LOAD_WORDS - 1);
    localparam logic [7:0] ABORT_LAST = 8'(ABORT_LEN - 1);
    localparam logic [7:0] BUSY_LAST = 8'(BUSY_EVERY - 1);
    localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYCLES - 1);

    typedef struct packed {
        seq_e        seq;
        logic [15:0] count;
        logic        synced;
        logic [1:0]  byte_pos;
        logic [31:0] word;
        logic [31:0] shadow;
        logic [15:0] words;
        logic        last_write_n;
        logic        was_selected;
        logic        busy;
        logic [7:0]  busy_count;
        logic [7:0]  pace;
        logic        aborting;
        logic [2:0]  stage;
        logic        done;
        logic        global_output_tristate;
        logic        global_set_reset;
        logic        tap_mode;
        logic [7:0]  data_out;
        logic        data_oe_n;
        logic [1:0]  rd_pos;
        logic        init_oe_n;
    } seq_s;
    seq_s state;
    seq_s next_state;

    logic [2:0] pins_level;
    logic [2:0] pins_rise;
    logic [4:0] link_level;
    logic [4:0] link_rise;
    logic [12:0] ctl_level;
    cfg_bus_if tap_bus ();

    // config clock, tck and the program pin cross in two flops
    edge_sync #(.WIDTH(3)) u_clk_sync (
        .clock (CLOCK),
        .nrst  (NRST),
        .din   ({CONFIG_CLOCK, TCK, PROGRAM_N}),
        .level (pins_level),
        .rise  (pins_rise)
    );
    edge_sync #(.WIDTH(5)) u_line_sync (
        .clock (CLOCK),
        .nrst  (NRST),
        .din   ({INIT_IN, DONE_LINE, MODE_SELECT_2, MODE_SELECT_1, MODE_SELECT_0}),
        .level (link_level),
        .rise  (link_rise)
    );
    edge_sync #(.WIDTH(13)) u_ctl_sync (
        .clock (CLOCK),
        .nrst  (NRST),
        .din   ({CS_N, WRITE_N, DATA_IN, CLOCK_LOCKED, TMS, TDI}),
        .level (ctl_level),
        .rise  ()
    );
    tap_loader u_tap (
        .clock     (CLOCK),
        .nrst      (NRST),
        .tck_rise  (pins_rise[1]),
        .tms       (ctl_level[1]),
        .tdi       (ctl_level[0]),
        .program_n (pins_level[0]),
        .bus       (tap_bus)
    );

    logic       config_clock_rise;
    logic       prog_n;
    logic       init_high;
    logic       done_line;
    logic       cs_n;
    logic       wr_n;
    logic [7:0] din;
    logic       locked;
    assign config_clock_rise = pins_rise[2];
    assign prog_n = pins_level[0];
    assign init_high = link_level[4];
    assign done_line = link_level[3];
    assign cs_n = ctl_level[12];
    assign wr_n = ctl_level[11];
    assign din = ctl_level[10:3];
    assign locked = ctl_level[2];

    // swap bit order: pin 0 carries the byte's msb
    function automatic logic [7:0] flip(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            flip[i] = b[7 - i];
        end
    endfunction

    // stage gating: done-line and lock waits
    function automatic logic stage_ok(input logic [2:0] s, input logic dl, input logic lk);
        stage_ok = (!WAIT_DONE_LINE || dl) && (!WAIT_LOCK || s < LOCK_STAGE || lk);
    endfunction

    // sequencer and parallel port
    always_comb begin
        logic       accept;
        logic       got_byte;
        logic [7:0] b;
        accept = 1'b0;
        got_byte = 1'b0;
        b = 8'h00;
        next_state = state;
        next_state.tap_mode = link_level[2:0] inside {MODE_TAP_A, MODE_TAP_B};
        if (!prog_n) begin
            // reconfiguration request restarts from clearing
            next_state = '0;
            next_state.seq = SEQ_CLEAR;
            next_state.global_output_tristate = 1'b1;
            next_state.global_set_reset = 1'b1;
            next_state.init_oe_n = 1'b0;
            next_state.data_oe_n = 1'b1;
            next_state.last_write_n = 1'b1;
            next_state.tap_mode = state.tap_mode;
        end else begin
            if (config_clock_rise) begin
                if (state.aborting) begin
                    // busy holds until the aborted operation finishes
                    next_state.busy_count = state.busy_count + 8'h01;
                    if (state.busy_count == ABORT_LAST) begin
                        next_state.aborting = 1'b0;
                        next_state.busy = 1'b0;
                    end
                end else if (!cs_n) begin
                    if (state.was_selected && wr_n != state.last_write_n) begin
                        // direction switch under select: abort, lose alignment
                        next_state.aborting = 1'b1;
                        next_state.busy = 1'b1;
                        next_state.busy_count = 8'h00;
                        next_state.synced = 1'b0;
                        next_state.byte_pos = 2'h0;
                        next_state.word = '0;
                    end else if (!wr_n) begin
                        accept = !state.busy;
                        next_state.pace = state.pace + 8'h01;
                        // outside an abort, busy rises only at fast clocks
                        next_state.busy = FAST_CLOCK && !state.busy
                            && state.pace == BUSY_LAST;
                        if (next_state.busy || !FAST_CLOCK) begin
                            next_state.pace = 8'h00;
                        end
                    end else begin
                        // readback: word shadow goes out a byte per clock
                        next_state.data_out = flip(state.shadow[31 - 8 * state.rd_pos -: 8]);
                        next_state.rd_pos = state.rd_pos + 2'h1;
                    end
                    next_state.last_write_n = wr_n;
                    next_state.was_selected = 1'b1;
                end else begin
                    // deselected: packet state is kept for the next select
                    next_state.was_selected = 1'b0;
                    next_state.busy = 1'b0;
                end
            end
            next_state.data_oe_n = cs_n
                || (config_clock_rise ? (!wr_n || state.aborting) : state.data_oe_n);
            if (accept) begin
                got_byte = 1'b1;
                b = flip(din);
            end else if (tap_bus.byte_valid) begin
                got_byte = 1'b1;
                b = tap_bus.byte_data;
            end
            unique case (state.seq)
                SEQ_CLEAR: begin
                    next_state.init_oe_n = 1'b0;
                    next_state.count = state.count + 16'h0001;
                    if (state.count == CLEAR_LAST) begin
                        next_state.seq = SEQ_WAIT_INIT;
                        next_state.init_oe_n = 1'b1;
                    end
                end
                SEQ_WAIT_INIT: begin
                    if (init_high) begin
                        next_state.seq = SEQ_LOAD;
                        next_state.count = 16'h0000;
                    end
                end
                SEQ_LOAD: begin
                    if (got_byte) begin
                        next_state.word = {state.word[23:0], b};
                        if (!state.synced) begin
                            if ({state.word[23:0], b} == SYNC_WORD) begin
                                next_state.synced = 1'b1;
                                next_state.byte_pos = 2'h0;
                            end
                        end else begin
                            next_state.byte_pos = state.byte_pos + 2'h1;
                            if (state.byte_pos == 2'h3) begin
                                next_state.shadow = {state.word[23:0], b};
                                next_state.words = state.words + 16'h0001;
                                if (state.words == LOAD_LAST) begin
                                    next_state.seq = SEQ_STARTUP;
                                    next_state.done = 1'b1;
                                    next_state.stage = 3'h0;
                                end
                            end
                        end
                    end
                end
                SEQ_STARTUP: begin
                    if ((config_clock_rise || tap_bus.startup_step)
                        && stage_ok(state.stage, done_line, locked)) begin
                        next_state.stage = state.stage + 3'h1;
                        if (state.stage + 3'h1 >= GTS_STAGE) begin
                            next_state.global_output_tristate = 1'b0;
                        end
                        if (state.stage + 3'h1 >= GSR_STAGE) begin
                            next_state.global_set_reset = 1'b0;
                        end
                        if (state.stage + 3'h1 >= STAGE_LAST && state.stage + 3'h1 >= GTS_STAGE
                            && state.stage + 3'h1 >= GSR_STAGE) begin
                            next_state.seq = SEQ_RUN;
                        end
                    end
                end
                SEQ_RUN: begin
                    next_state.global_output_tristate = 1'b0;
                    next_state.global_set_reset = 1'b0;
                end
                default: begin
                    next_state.seq = SEQ_CLEAR;
                end
            endcase
        end
    end

    // power-up starts the clear phase with outputs held
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state <= '{seq: SEQ_CLEAR, global_output_tristate: 1'b1, global_set_reset: 1'b1, data_oe_n: 1'b1,
                       last_write_n: 1'b1, init_oe_n: 1'b0, default: '0};
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from state flops, except constant INIT_OUT and inverted write enable
    assign DATA_OUT = state.data_out;
    assign DATA_OE_N = state.data_oe_n;
    assign BUSY = state.busy;
    assign INIT_OUT = 1'b0;
    assign INIT_OE_N = state.init_oe_n;
    assign DONE = state.done;
    assign GLOBAL_OUTPUT_TRISTATE = state.global_output_tristate;
    assign GLOBAL_SET_RESET = state.global_set_reset;
    assign GLOBAL_WRITE_ENABLE = !state.global_set_reset;
    assign TAP_MODE = state.tap_mode;
    assign SYNCED = state.synced;
endmodule

/* sim/config_port_sequencer_monitor.sv */
module config_port_sequencer_monitor
    import cfg_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CS_N,
    input wire logic WRITE_N,
    input wire logic PROGRAM_N,
    input wire logic INIT_IN,
    input wire logic INIT_OE_N,
    input wire logic DONE,
    input wire logic DATA_OE_N,
    input wire logic MODE_SELECT_2,
    input wire logic MODE_SELECT_1,
    input wire logic MODE_SELECT_0,
    input wire logic TAP_MODE,
    input wire logic GLOBAL_OUTPUT_TRISTATE,
    input wire logic GLOBAL_SET_RESET,
    input wire logic GLOBAL_WRITE_ENABLE
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);
    logic tap_code;
    // mode pins asking for the test port
    assign tap_code = {MODE_SELECT_2, MODE_SELECT_1, MODE_SELECT_0} inside {MODE_TAP_A, MODE_TAP_B};
    init_before_done_a: assert property ($rose(DONE) |-> INIT_OE_N && INIT_IN)
        else $error("done rose while init low");
    tristate_release_a: assert property ($fell(GLOBAL_OUTPUT_TRISTATE) |-> DONE)
        else $error("tristate released before done");
    set_reset_order_a: assert property ($fell(GLOBAL_SET_RESET) |-> !GLOBAL_OUTPUT_TRISTATE)
        else $error("set/reset released before tristate");
    write_enable_pair_a: assert property (GLOBAL_WRITE_ENABLE != GLOBAL_SET_RESET)
        else $error("write enable not opposite set/reset");
    deselect_release_a: assert property (CS_N [*6] |-> DATA_OE_N)
        else $error("data driven while deselected");
    readback_drive_a: assert property ($fell(DATA_OE_N) |-> !CS_N && WRITE_N)
        else $error("data driven outside read");
    reconfig_clear_a: assert property (!PROGRAM_N [*6] |-> !DONE && !INIT_OE_N)
        else $error("reconfig did not restart");
    tap_select_a: assert property ($stable(tap_code) [*4] |-> TAP_MODE == tap_code)
        else $error("test port mode wrong");
endmodule

/* sim/cfg_host_model.sv */
module cfg_host_model (
    input  wire logic       busy,
    output logic            cfg_clock,
    output logic            cs_n,
    output logic            write_n,
    output logic      [7:0] data
);
    timeunit 1ns;
    timeprecision 100ps;
    int lost = 0;
    // clock stands low outside frames; the port starts deselected and keeps the last frame's select level
    initial begin
        cfg_clock = 1'b0;
        cs_n = 1'b1;
        write_n = 1'b1;
        data = 8'h5a;
    end
    // the byte's msb goes out on line 0
    function automatic logic [7:0] pins(input logic [7:0] b);
        for (int i = 0; i < 8; i++) pins[i] = b[7 - i];
    endfunction
    // one 125 ns config clock; a write counts only if busy was low at the rise
    task automatic cycle(input logic cs, input logic wr, input logic [7:0] b, output logic took);
        cs_n <= cs;
        write_n <= wr;
        data <= (!cs && !wr) ? pins(b) : ~data;
        #62.5;
        took = !cs && !wr && !busy;
        cfg_clock <= 1'b1;
        #62.5;
        cfg_clock <= 1'b0;
    endtask
    // byte held for up to 16 clocks until taken
    task automatic send(input logic [7:0] b);
        logic took;
        took = 1'b0;
        for (int n = 0; n < 16 && !took; n++) cycle(1'b0, 1'b0, b, took);
        if (!took) lost++;
    endtask
endmodule

/* sim/parallel_config_port_sequencer_bench.sv */
module parallel_config_port_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cfg_pkg::*;
    logic       CLOCK = 1'b0;
    logic       NRST = 1'b0;
    logic       PROGRAM_N = 1'b1;
    logic       ext_init = 1'b0;
    logic       FAST_CLOCK = 1'b0;
    logic [2:0] mode = 3'h0;
    logic       tck = 1'b0, tms = 1'b0, tdi = 1'b0, wait_lock = 1'b0, locked = 1'b0;
    logic       cfg_clock, cs_n, write_n, busy, init_in, init_out, init_oe_n, done;
    logic       data_oe_n, global_output_tristate, global_set_reset, global_write_enable, tap_mode, synced;
    logic [7:0] data_in, data_out;
    int         fail_count = 0;
    int         checked = 0;
    int         busy_seen = 0;
    always #5 CLOCK = ~CLOCK;
    // open-drain init wire with an outside driver
    assign init_in = (init_oe_n ? 1'b1 : init_out) & ext_init;
    always @(posedge busy) busy_seen++;
    cfg_host_model host (.busy(busy), .cfg_clock(cfg_clock), .cs_n(cs_n), .write_n(write_n),
        .data(data_in));
    config_port_sequencer #(.LOAD_WORDS(2)) dut (
        .CLOCK(CLOCK), .NRST(NRST), .CONFIG_CLOCK(cfg_clock), .CS_N(cs_n), .WRITE_N(write_n),
        .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n), .BUSY(busy),
        .PROGRAM_N(PROGRAM_N), .INIT_IN(init_in), .INIT_OUT(init_out), .INIT_OE_N(init_oe_n),
        .DONE(done), .DONE_LINE(done), .MODE_SELECT_2(mode[2]), .MODE_SELECT_1(mode[1]),
        .MODE_SELECT_0(mode[0]), .TCK(tck), .TMS(tms), .TDI(tdi), .FAST_CLOCK(FAST_CLOCK),
        .GTS_STAGE(STAGE_GTS_DEFAULT), .GSR_STAGE(STAGE_GSR_DEFAULT), .WAIT_DONE_LINE(1'b0),
        .WAIT_LOCK(wait_lock), .LOCK_STAGE(3'h0), .CLOCK_LOCKED(locked),
        .GLOBAL_OUTPUT_TRISTATE(global_output_tristate),
        .GLOBAL_SET_RESET(global_set_reset), .GLOBAL_WRITE_ENABLE(global_write_enable), .TAP_MODE(tap_mode), .SYNCED(synced));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
    endtask
    task automatic idle(input int n);
        logic t;
        repeat (n) host.cycle(1'b1, 1'b1, 8'h00, t);
    endtask
    // optional sync word then two words, optionally split by a deselected clock
    task automatic load(input bit sync, input bit gap);
        logic t;
        for (int i = 3; i >= 0 && sync; i--) host.send(SYNC_WORD[8*i +: 8]);
        for (int k = 1; k <= 8; k++) begin
            host.send(8'(k * 17));
            if (gap && k == 3) host.cycle(1'b1, 1'b1, 8'h00, t);
        end
    endtask
    // bounded wait for the end of memory clearing
    task automatic wait_init;
        for (int n = 0; n < 400 && init_oe_n !== 1'b1; n++) tick(1);
        chk(init_oe_n, 1'b1);
        if (init_oe_n !== 1'b1) final_report;
    endtask
    initial begin
        logic t;
        tick(3);
        NRST <= 1'b1;
        wait_init;
        load(1'b1, 1'b0);
        chk(done, 1'b0);
        $display("test init_hold finished");
        tick(1);
        ext_init <= 1'b1;
        tick(5);
        for (int i = 3; i >= 0; i--) host.send(SYNC_WORD[8*i +: 8]);
        chk(synced, 1'b1);
        host.send(8'h11);
        chk(busy_seen, 0);
        host.cycle(1'b0, 1'b1, 8'h00, t);
        chk({busy, synced}, 2'b10);
        idle(ABORT_CYCLES + 1);
        chk(busy, 1'b0);
        load(1'b0, 1'b0);
        chk(done, 1'b0);
        $display("test abort finished");
        tick(1);
        FAST_CLOCK <= 1'b1;
        wait_lock <= 1'b1;
        busy_seen = 0;
        load(1'b1, 1'b1);
        chk({done, global_output_tristate}, 2'b11);
        chk(busy_seen > 0, 1'b1);
        idle(2);
        chk(global_output_tristate, 1'b1);
        tick(1);
        locked <= 1'b1;
        tick(3);
        idle(1);
        chk({global_output_tristate, global_set_reset}, 2'b01);
        idle(1);
        chk({global_set_reset, global_write_enable}, 2'b01);
        host.cycle(1'b0, 1'b1, 8'h00, t);
        chk({data_oe_n, data_out}, {1'b0, host.pins(8'h55)});
        idle(2);
        chk(data_oe_n, 1'b1);
        $display("test load_readback finished");
        for (int m = 0; m < 8; m++) begin
            @(posedge CLOCK);
            mode <= 3'(m);
            tick(6);
            chk(tap_mode, 1'(m == 5 || m == 1));
        end
        $display("test mode_select finished");
        PROGRAM_N <= 1'b0;
        tick(10);
        chk({done, init_oe_n, global_output_tristate}, 3'b001);
        PROGRAM_N <= 1'b1;
        wait_init;
        chk(host.lost, 0);
        $display("test reconfig finished");
        final_report;
    end
endmodule
bind config_port_sequencer config_port_sequencer_monitor mon (
    .CLOCK(CLOCK), .NRST(NRST), .CS_N(CS_N), .WRITE_N(WRITE_N), .PROGRAM_N(PROGRAM_N),
    .INIT_IN(INIT_IN), .INIT_OE_N(INIT_OE_N), .DONE(DONE), .DATA_OE_N(DATA_OE_N),
    .MODE_SELECT_2(MODE_SELECT_2), .MODE_SELECT_1(MODE_SELECT_1), .MODE_SELECT_0(MODE_SELECT_0),
    .TAP_MODE(TAP_MODE), .GLOBAL_OUTPUT_TRISTATE(GLOBAL_OUTPUT_TRISTATE),
    .GLOBAL_SET_RESET(GLOBAL_SET_RESET), .GLOBAL_WRITE_ENABLE(GLOBAL_WRITE_ENABLE));
